/* File: hw/mif_decoder.sv */
// Instruction word decoder and cycle sequencer of the 8-bit core.
// Assumes prog_word holds the fetched word whenever cycle_end pulses and
// cond_true is the test result of the executing instruction, both on mclk.
// Behaviour
// - Decode the 75 standard instructions and 8 extended ones when enabled.
// - A single instruction word is 16 bits: opcode plus operand fields.
// - Sort instructions into byte, bit, literal and control groups.
// - Exactly four instructions span two words, 32 bits in all.
// - Second words start with four ones and run alone as no-operation.
// - Byte destination bit 0 selects accumulator, 1 selects file register.
// - Bit field picks which bit of the file register is affected.
// - Literal instructions give a constant and optional pointer choice.
// - Control instructions give address, call/return mode and table mode.
// - Single word takes one cycle, two when taken or changing flow, three when skipping a double word.
// - Every double-word instruction takes two instruction cycles.
// - One instruction cycle lasts four oscillator periods.
// - Access bit 0 uses access bank; 1 uses the ram bank selector.
// - File operand is 8-bit address or 2-bit pointer designator.
// - Fast bit 1 saves or restores shadow registers; 0 leaves them.
// - Table mode: no change, post-increment, post-decrement, pre-increment.
`timescale 1ns/1ps
`default_nettype none
module mif_decoder (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [15:0] prog_word,
  input wire logic cond_true,
  input wire logic ext_set_enable,
  output logic cycle_end,
  output logic [mif_pkg::PHASE_W-1:0] osc_phase,
  output logic exec_active,
  output logic redirect,
  output logic [1:0] ins_group,
  output logic [15:0] ins_word,
  output logic ins_double,
  output logic ins_nop,
  output logic ins_skip,
  output logic ins_cond_branch,
  output logic [2:0] cond_sel,
  output logic to_working_accumulator,
  output logic to_file_register,
  output logic use_ram_bank_selector,
  output logic [7:0] file_addr,
  output logic [7:0] bit_mask,
  output logic [1:0] indirect_pointer_sel,
  output logic [11:0] addr_src,
  output logic [11:0] addr_dst,
  output logic [11:0] literal_value,
  output logic [19:0] prog_addr,
  output logic prog_addr_rel,
  output logic shadow_save,
  output logic shadow_restore,
  output logic tbl_read,
  output logic tbl_write,
  output logic tbl_pre_inc,
  output logic tbl_post_step,
  output logic tbl_step_down,
  output logic ext_valid,
  output logic [mif_pkg::EXT_OP_W-1:0] ext_op
);

  typedef struct packed {
    mif_pkg::mif_seq_e st;
    logic [15:0] hold;
    logic exec;
    mif_pkg::mif_dec_s dec;
  } mif_core_s;

  mif_core_s s_q;
  mif_core_s s_d;
  mif_pkg::mif_seq_e nxt;
  logic cyc_en;
  logic taken;
  logic skipping;

  // True for the first word of one of the four double-word instructions
  function automatic logic is_dw(input logic [15:0] w);
    logic [3:0] maj;
    maj = w[15:12];
    is_dw = (maj == mif_pkg::MAJ_MOVE_FF) ||
            ((maj == mif_pkg::MAJ_LIT) && (w[11:8] == mif_pkg::LIT_PTR_LOAD)) ||
            ((maj == mif_pkg::MAJ_CTL) && (w[11:9] == mif_pkg::CTL_CALL_ABS)) ||
            ((maj == mif_pkg::MAJ_CTL) && (w[11:8] == mif_pkg::CTL_GOTO_ABS));
  endfunction : is_dw

  // Split one word, or a word pair, into its operand fields
  function automatic mif_pkg::mif_dec_s decode_word(input logic [15:0] w,
                                                    input logic [15:0] w2,
                                                    input logic ext_en);
    mif_pkg::mif_dec_s d;
    logic [3:0] maj;
    d = '0;
    maj = w[15:12];
    d.dw = is_dw(w);
    case (maj)
      mif_pkg::MAJ_BIT_SET, mif_pkg::MAJ_BIT_SKC, mif_pkg::MAJ_BIT_SKS,
      mif_pkg::MAJ_BIT_CLR: begin
        d.grp = mif_pkg::GRP_BIT;
        d.bank_sel = w[mif_pkg::A_POS];
        d.file_addr = w[7:0];
        d.bit_mask = 8'h01 << w[11:9];
        d.skip = (maj == mif_pkg::MAJ_BIT_SKC) || (maj == mif_pkg::MAJ_BIT_SKS);
      end
      mif_pkg::MAJ_MOVE_FF: begin
        d.grp = mif_pkg::GRP_BYTE;
        d.addr_src = w[11:0];
        d.addr_dst = w2[11:0];
      end
      mif_pkg::MAJ_EXT: begin
        d.grp = mif_pkg::GRP_LIT;
        d.ext_valid = ext_en;
        d.ext_op = w[11:9];
        d.literal = {4'h0, w[7:0]};
        d.nop = !ext_en;
      end
      mif_pkg::MAJ_LIT: begin
        d.grp = mif_pkg::GRP_LIT;
        d.literal = {4'h0, w[7:0]};
        if (w[11:8] == mif_pkg::LIT_PTR_LOAD) begin
          d.ptr_sel = w[5:4];
          d.literal = {w[3:0], w2[7:0]};
        end
      end
      mif_pkg::MAJ_BRA_REL: begin
        d.grp = mif_pkg::GRP_CTL;
        d.pc_change = 1'b1;
        d.rel = 1'b1;
        d.prog_addr = {{9{w[10]}}, w[10:0]};
      end
      mif_pkg::MAJ_CTL: begin
        d.grp = mif_pkg::GRP_CTL;
        if (!w[mif_pkg::COND_POS]) begin
          d.cond_branch = 1'b1;
          d.cond_sel = w[10:8];
          d.rel = 1'b1;
          d.prog_addr = {{12{w[7]}}, w[7:0]};
        end else if (w[11:9] == mif_pkg::CTL_CALL_ABS) begin
          d.pc_change = 1'b1;
          d.fast_save = w[mif_pkg::CALL_S_POS];
          d.prog_addr = {w2[11:0], w[7:0]};
        end else if (w[11:8] == mif_pkg::CTL_GOTO_ABS) begin
          d.pc_change = 1'b1;
          d.prog_addr = {w2[11:0], w[7:0]};
        end else begin
          d.nop = 1'b1;
        end
      end
      mif_pkg::MAJ_WORD2: begin
        d.grp = mif_pkg::GRP_CTL;
        d.nop = 1'b1;
      end
      default: begin
        if (w[15:4] == mif_pkg::MISC_PREFIX) begin
          d.grp = mif_pkg::GRP_CTL;
          if (w[mif_pkg::TBL_SEL_POS]) begin
            d.tbl_read = !w[mif_pkg::TBL_DIR_POS];
            d.tbl_write = w[mif_pkg::TBL_DIR_POS];
            case (w[1:0])
              mif_pkg::TM_POST_INC: d.tbl_post = 1'b1;
              mif_pkg::TM_POST_DEC: begin
                d.tbl_post = 1'b1;
                d.tbl_down = 1'b1;
              end
              mif_pkg::TM_PRE_INC: d.tbl_pre = 1'b1;
              default: d.tbl_pre = 1'b0;
            endcase
          end else if (w[3:1] == mif_pkg::MISC_RETURN) begin
            d.pc_change = 1'b1;
            d.fast_restore = w[mif_pkg::RET_S_POS];
          end else begin
            d.nop = 1'b1;
          end
        end else begin
          d.grp = mif_pkg::GRP_BYTE;
          d.dest_file = w[mif_pkg::D_POS];
          d.dest_accum = !w[mif_pkg::D_POS];
          d.bank_sel = w[mif_pkg::A_POS];
          d.file_addr = w[7:0];
          d.skip = (w[15:10] == mif_pkg::BYTE_OP_SKIP);
        end
      end
    endcase
    decode_word = d;
  endfunction : decode_word

  mif_phase_div #(
    .PERIODS(mif_pkg::OSC_PER_CYCLE)
  ) u_phase (
    .mclk(mclk),
    .resetn(resetn),
    .phase(osc_phase),
    .cyc_en(cyc_en)
  );

  // Flow change or true test of the single-word instruction now executing
  assign taken = (s_q.st == mif_pkg::SQ_EXEC) &&
                 (s_q.dec.pc_change || (s_q.dec.cond_branch && cond_true));
  assign skipping = (s_q.st == mif_pkg::SQ_EXEC) && s_q.dec.skip && cond_true;

  // Classify the incoming word and latch its fields at each cycle end
  always_comb begin
    s_d = s_q;
    nxt = is_dw(prog_word) ? mif_pkg::SQ_FIRST : mif_pkg::SQ_EXEC;
    case (s_q.st)
      mif_pkg::SQ_FIRST: nxt = mif_pkg::SQ_WORD2;
      mif_pkg::SQ_EXEC: begin
        if (taken) begin
          nxt = mif_pkg::SQ_FLUSH;
        end else if (skipping) begin
          nxt = mif_pkg::SQ_SKIP;
        end
      end
      mif_pkg::SQ_SKIP: begin
        if (is_dw(s_q.hold)) begin
          nxt = mif_pkg::SQ_SKIP2;
        end
      end
      default: begin
      end
    endcase
    if (cyc_en) begin
      s_d.st = nxt;
      s_d.hold = prog_word;
      s_d.exec = (nxt == mif_pkg::SQ_EXEC) || (nxt == mif_pkg::SQ_WORD2);
      case (nxt)
        mif_pkg::SQ_EXEC, mif_pkg::SQ_FIRST: begin
          s_d.dec = decode_word(prog_word, mif_pkg::WORD2_FILL, ext_set_enable);
        end
        mif_pkg::SQ_WORD2: begin
          s_d.dec = decode_word(s_q.hold, prog_word, ext_set_enable);
        end
        default: begin
          s_d.dec = '0;
          s_d.dec.nop = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Sequencer status and decoded fields
  assign cycle_end = cyc_en;
  assign redirect = cyc_en && taken;
  assign exec_active = s_q.exec;
  assign ins_word = s_q.hold;
  assign ins_group = s_q.dec.grp;
  assign ins_double = s_q.dec.dw;
  assign ins_nop = s_q.dec.nop;
  assign ins_skip = s_q.dec.skip;
  assign ins_cond_branch = s_q.dec.cond_branch;
  assign cond_sel = s_q.dec.cond_sel;
  assign to_working_accumulator = s_q.dec.dest_accum;
  assign to_file_register = s_q.dec.dest_file;
  assign use_ram_bank_selector = s_q.dec.bank_sel;
  assign file_addr = s_q.dec.file_addr;
  assign bit_mask = s_q.dec.bit_mask;
  assign indirect_pointer_sel = s_q.dec.ptr_sel;
  assign addr_src = s_q.dec.addr_src;
  assign addr_dst = s_q.dec.addr_dst;
  assign literal_value = s_q.dec.literal;
  assign prog_addr = s_q.dec.prog_addr;
  assign prog_addr_rel = s_q.dec.rel;
  assign shadow_save = s_q.dec.fast_save;
  assign shadow_restore = s_q.dec.fast_restore;
  assign tbl_read = s_q.dec.tbl_read;
  assign tbl_write = s_q.dec.tbl_write;
  assign tbl_pre_inc = s_q.dec.tbl_pre;
  assign tbl_post_step = s_q.dec.tbl_post;
  assign tbl_step_down = s_q.dec.tbl_down;
  assign ext_valid = s_q.dec.ext_valid;
  assign ext_op = s_q.dec.ext_op;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  AST_CYCLE_SPAN: assert property (cyc_en |=> (!cyc_en)[*3] ##1 cyc_en)
    else $error("instruction cycle is not four clocks");
  AST_FLUSH_AFTER_TAKEN: assert property (redirect |=> (!exec_active && ins_nop)[*4])
    else $error("refill cycle after flow change executed");
  AST_NOT_TAKEN_NO_FLUSH: assert property (
    (cyc_en && s_q.st == mif_pkg::SQ_EXEC && !s_q.dec.pc_change && !s_q.dec.skip && !cond_true)
    |=> s_q.st != mif_pkg::SQ_FLUSH && s_q.st != mif_pkg::SQ_SKIP)
    else $error("extra cycle without taken test");
  AST_DW_TWO_CYCLES: assert property (
    (cyc_en && s_q.st == mif_pkg::SQ_FIRST && !exec_active)
    |=> (s_q.st == mif_pkg::SQ_WORD2 && exec_active && ins_double)[*4])
    else $error("double-word instruction not executed in second cycle");
  AST_SKIP_DW: assert property (
    (cyc_en && s_q.st == mif_pkg::SQ_SKIP && is_dw(s_q.hold))
    |=> (s_q.st == mif_pkg::SQ_SKIP2 && !exec_active)[*4])
    else $error("second word of skipped instruction not suppressed");
  AST_WORD2_NOP: assert property (
    (exec_active && s_q.st == mif_pkg::SQ_EXEC && s_q.hold[15:12] == mif_pkg::MAJ_WORD2)
    |-> ins_nop && !s_q.dec.pc_change && !ins_double)
    else $error("lone second word not a no-operation");
  AST_DEST_SELECT: assert property (
    (s_q.st == mif_pkg::SQ_EXEC && ins_group == mif_pkg::GRP_BYTE && !ins_double)
    |-> to_file_register == s_q.hold[mif_pkg::D_POS] && to_working_accumulator != to_file_register)
    else $error("destination select does not follow d bit");
  AST_BIT_MASK: assert property (
    (s_q.st == mif_pkg::SQ_EXEC && ins_group == mif_pkg::GRP_BIT)
    |-> bit_mask == (8'h01 << s_q.hold[11:9]) && use_ram_bank_selector == s_q.hold[8])
    else $error("bit mask or bank select wrong");
  AST_SHADOW_USE: assert property (
    (shadow_save || shadow_restore) |-> ins_group == mif_pkg::GRP_CTL && s_q.dec.pc_change)
    else $error("shadow use outside call or return");
  AST_TBL_MODE: assert property (
    (tbl_pre_inc |-> !tbl_post_step && !tbl_step_down) and
    (tbl_step_down |-> tbl_post_step) and ((tbl_pre_inc || tbl_post_step) |-> tbl_read || tbl_write))
    else $error("table pointer mode inconsistent");
  AST_EXT_OP: assert property (
    ext_valid |-> s_q.hold[15:12] == mif_pkg::MAJ_EXT && ext_op == s_q.hold[11:9] && !ins_nop)
    else $error("extended op field wrong");

endmodule : mif_decoder
`default_nettype wire

/* File: hw/mif_pkg.sv */
// Shared constants and types for the instruction format and timing decoder.
// Assumes one core clock in which four periods make one instruction cycle.
package mif_pkg;

  // Instruction cycle timing in oscillator periods
  localparam int OSC_PER_CYCLE = 4;
  localparam int PHASE_W = 2;

  // Instruction set size
  localparam int NUM_STD_OPS = 75;
  localparam int NUM_EXT_OPS = 8;
  localparam int EXT_OP_W = 3;

  // Major opcode nibble, word bits 15:12
  localparam logic [3:0] MAJ_BYTE_LAST = 4'h5;
  localparam logic [3:0] MAJ_BIT_SET = 4'h6;
  localparam logic [3:0] MAJ_BIT_SKC = 4'h7;
  localparam logic [3:0] MAJ_BIT_SKS = 4'h8;
  localparam logic [3:0] MAJ_BIT_CLR = 4'h9;
  localparam logic [3:0] MAJ_MOVE_FF = 4'ha;
  localparam logic [3:0] MAJ_EXT = 4'hb;
  localparam logic [3:0] MAJ_LIT = 4'hc;
  localparam logic [3:0] MAJ_BRA_REL = 4'hd;
  localparam logic [3:0] MAJ_CTL = 4'he;
  localparam logic [3:0] MAJ_WORD2 = 4'hf;

  // Minor codes
  localparam logic [5:0] BYTE_OP_SKIP = 6'h17;
  localparam logic [3:0] LIT_PTR_LOAD = 4'he;
  localparam logic [2:0] CTL_CALL_ABS = 3'h6;
  localparam logic [3:0] CTL_GOTO_ABS = 4'hf;
  localparam logic [11:0] MISC_PREFIX = 12'h000;
  localparam logic [2:0] MISC_RETURN = 3'h1;

  // Field positions
  localparam int D_POS = 9;
  localparam int A_POS = 8;
  localparam int CALL_S_POS = 8;
  localparam int RET_S_POS = 0;
  localparam int TBL_SEL_POS = 3;
  localparam int TBL_DIR_POS = 2;
  localparam int COND_POS = 11;

  // Table pointer step modes
  localparam logic [1:0] TM_NONE = 2'h0;
  localparam logic [1:0] TM_POST_INC = 2'h1;
  localparam logic [1:0] TM_POST_DEC = 2'h2;
  localparam logic [1:0] TM_PRE_INC = 2'h3;

  // Filler used as second word when a word is decoded alone
  localparam logic [15:0] WORD2_FILL = 16'hf000;

  typedef enum logic [1:0] {
    GRP_BYTE = 2'h0,
    GRP_BIT = 2'h1,
    GRP_LIT = 2'h2,
    GRP_CTL = 2'h3
  } mif_group_e;

  typedef enum logic [2:0] {
    SQ_FLUSH = 3'h0,
    SQ_EXEC = 3'h1,
    SQ_FIRST = 3'h2,
    SQ_WORD2 = 3'h3,
    SQ_SKIP = 3'h4,
    SQ_SKIP2 = 3'h5
  } mif_seq_e;

  typedef struct packed {
    mif_group_e grp;
    logic dw;
    logic pc_change;
    logic cond_branch;
    logic [2:0] cond_sel;
    logic skip;
    logic nop;
    logic dest_file;
    logic dest_accum;
    logic bank_sel;
    logic [7:0] file_addr;
    logic [7:0] bit_mask;
    logic [1:0] ptr_sel;
    logic [11:0] addr_src;
    logic [11:0] addr_dst;
    logic [11:0] literal;
    logic [19:0] prog_addr;
    logic rel;
    logic fast_save;
    logic fast_restore;
    logic tbl_read;
    logic tbl_write;
    logic tbl_pre;
    logic tbl_post;
    logic tbl_down;
    logic ext_valid;
    logic [EXT_OP_W-1:0] ext_op;
  } mif_dec_s;

endpackage : mif_pkg

/* File: hw/mif_phase_div.sv */
// Quarter-phase divider making one instruction cycle from four core clocks.
// Assumes mclk is the oscillator clock and resetn is synchronous, active low.
`timescale 1ns/1ps
`default_nettype none
module mif_phase_div #(
  parameter int PERIODS = mif_pkg::OSC_PER_CYCLE
) (
  input wire logic mclk,
  input wire logic resetn,
  output logic [mif_pkg::PHASE_W-1:0] phase,
  output logic cyc_en
);

  typedef struct packed {
    logic [mif_pkg::PHASE_W-1:0] cnt;
  } mif_div_s;

  localparam logic [mif_pkg::PHASE_W-1:0] LAST = mif_pkg::PHASE_W'(PERIODS - 1);

  mif_div_s s_q;
  mif_div_s s_d;

  // Wrap the phase counter once per instruction cycle
  always_comb begin
    s_d = s_q;
    if (s_q.cnt == LAST) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Enable pulse in the last quarter of each cycle
  assign cyc_en = (s_q.cnt == LAST);
  assign phase = s_q.cnt;

  AST_PHASE_STEP: assert property (@(posedge mclk) disable iff (!resetn)
    !cyc_en |=> phase == ($past(phase) + 2'h1))
    else $error("phase did not advance by one");

endmodule : mif_phase_div
`default_nettype wire

/* File: verification/mcu_instruction_format_timing_tb.sv */
// Self-checking bench for the instruction decoder and cycle sequencer.
// Assumes mif_decoder samples prog_word and cond_true at the edge where cycle_end is high.
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_format_timing_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] prog_word = 16'h0000;
  logic cond_true = 1'b0;
  logic ext_set_enable = 1'b0;
  logic cycle_end, exec_active, redirect, ins_double, ins_nop, ins_skip, ins_cond_branch;
  logic [1:0] osc_phase, ins_group, indirect_pointer_sel;
  logic [15:0] ins_word;
  logic [2:0] cond_sel, ext_op;
  logic to_working_accumulator, to_file_register, use_ram_bank_selector, prog_addr_rel;
  logic [7:0] file_addr, bit_mask;
  logic [11:0] addr_src, addr_dst, literal_value;
  logic [19:0] prog_addr;
  logic shadow_save, shadow_restore, tbl_read, tbl_write, tbl_pre_inc, tbl_post_step;
  logic tbl_step_down, ext_valid, redir_seen;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc_cnt = 0;

  mif_decoder i_mif_decoder (
    .mclk(mclk), .resetn(resetn), .prog_word(prog_word), .cond_true(cond_true),
    .ext_set_enable(ext_set_enable), .cycle_end(cycle_end), .osc_phase(osc_phase),
    .exec_active(exec_active), .redirect(redirect), .ins_group(ins_group),
    .ins_word(ins_word), .ins_double(ins_double), .ins_nop(ins_nop), .ins_skip(ins_skip),
    .ins_cond_branch(ins_cond_branch), .cond_sel(cond_sel),
    .to_working_accumulator(to_working_accumulator), .to_file_register(to_file_register),
    .use_ram_bank_selector(use_ram_bank_selector), .file_addr(file_addr),
    .bit_mask(bit_mask), .indirect_pointer_sel(indirect_pointer_sel), .addr_src(addr_src),
    .addr_dst(addr_dst), .literal_value(literal_value), .prog_addr(prog_addr),
    .prog_addr_rel(prog_addr_rel), .shadow_save(shadow_save),
    .shadow_restore(shadow_restore), .tbl_read(tbl_read), .tbl_write(tbl_write),
    .tbl_pre_inc(tbl_pre_inc), .tbl_post_step(tbl_post_step),
    .tbl_step_down(tbl_step_down), .ext_valid(ext_valid), .ext_op(ext_op)
  );

  // Core clock, 4 ns period
  always #2 mclk = ~mclk;

  // Hang guard
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 2000) begin
      error_cnt++;
      close_out();
    end
  end

  // Compare one value against its expectation
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Present one word at the next cycle_end edge, then wait for the decode to land
  task automatic step(input logic [15:0] w, input logic c);
    int n;
    n = 0;
    while (cycle_end !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    prog_word = w;
    cond_true = c;
    // Redirect of the executing instruction depends on the test result just driven
    #1;
    redir_seen = redirect;
    @(negedge mclk);
  endtask : step

  // Reset values and the four-period instruction cycle
  task automatic t_reset();
    repeat (12) @(negedge mclk);
    chk("exec_rst", exec_active, 0);
    chk("phase_rst", osc_phase, 0);
    chk("group_rst", ins_group, 0);
    resetn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      chk("phase", osc_phase, i % 4);
      chk("cycle_end", cycle_end, (i % 4) == 3);
      @(negedge mclk);
    end
    $display("test reset done");
  endtask : t_reset

  // Byte group: destination and access bits
  task automatic t_byte();
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      w = {6'h01, i[1], i[0], 8'h5a};
      step(w, 1'b0);
      chk("word", ins_word, w);
      chk("grp_byte", ins_group, 0);
      chk("exec", exec_active, 1);
      chk("to_acc", to_working_accumulator, !i[1]);
      chk("to_file", to_file_register, i[1]);
      chk("bank", use_ram_bank_selector, i[0]);
      chk("faddr", file_addr, 8'h5a);
    end
    $display("test byte done");
  endtask : t_byte

  // Bit group: every bit position
  task automatic t_bit();
    for (int b = 0; b < 8; b++) begin
      step({4'h6, b[2:0], 1'b1, 8'h33}, 1'b0);
      chk("grp_bit", ins_group, 1);
      chk("mask", bit_mask, 8'h01 << b);
      chk("faddr_bit", file_addr, 8'h33);
    end
    $display("test bit done");
  endtask : t_bit

  // Literal, pointer load pair and lone second word
  task automatic t_lit();
    step(16'hc0a5, 1'b0);
    chk("grp_lit", ins_group, 2);
    chk("lit", literal_value, 12'h0a5);
    chk("dbl_no", ins_double, 0);
    step(16'hce23, 1'b0);
    chk("exec_w1", exec_active, 0);
    chk("dbl_w1", ins_double, 1);
    step(16'hf07e, 1'b0);
    chk("exec_w2", exec_active, 1);
    chk("lit_ptr", literal_value, 12'h37e);
    chk("ptr_sel", indirect_pointer_sel, 2);
    step(16'hf123, 1'b0);
    chk("lone_nop", ins_nop, 1);
    chk("lone_exec", exec_active, 1);
    // File-to-file move pair carries both 12-bit addresses
    step(16'ha123, 1'b0);
    chk("mv_exec_w1", exec_active, 0);
    chk("mv_dbl_w1", ins_double, 1);
    step(16'hf456, 1'b0);
    chk("mv_exec_w2", exec_active, 1);
    chk("mv_grp", ins_group, 0);
    chk("mv_src", addr_src, 12'h123);
    chk("mv_dst", addr_dst, 12'h456);
    $display("test literal done");
  endtask : t_lit

  // Goto, call, return and branches with their cycle costs
  task automatic t_flow();
    step(16'hef12, 1'b0);
    step(16'hf345, 1'b0);
    chk("goto_addr", prog_addr, 20'h34512);
    chk("goto_rel", prog_addr_rel, 0);
    chk("goto_grp", ins_group, 3);
    step(16'hed00, 1'b0);
    chk("goto_redir", redir_seen, 0);
    step(16'hf000, 1'b0);
    chk("save1", shadow_save, 1);
    step(16'hec00, 1'b0);
    step(16'hf000, 1'b0);
    chk("save0", shadow_save, 0);
    step(16'h0003, 1'b0);
    chk("restore1", shadow_restore, 1);
    step(16'h0455, 1'b0);
    chk("ret_redir", redir_seen, 1);
    chk("refill_exec", exec_active, 0);
    chk("refill_nop", ins_nop, 1);
    step(16'h0002, 1'b0);
    chk("refill_redir", redir_seen, 0);
    chk("restore0", shadow_restore, 0);
    step(16'hf000, 1'b0);
    chk("ret0_redir", redir_seen, 1);
    step(16'hd7ff, 1'b0);
    chk("bra_rel", prog_addr_rel, 1);
    chk("bra_off", prog_addr, 20'hfffff);
    step(16'h0400, 1'b0);
    chk("bra_redir", redir_seen, 1);
    chk("bra_refill", exec_active, 0);
    step(16'he105, 1'b0);
    chk("cb_flag", ins_cond_branch, 1);
    chk("cb_sel", cond_sel, 1);
    chk("cb_off", prog_addr, 20'h00005);
    step(16'h0400, 1'b1);
    chk("cb_taken", redir_seen, 1);
    step(16'he105, 1'b0);
    step(16'h0400, 1'b0);
    chk("cb_held", redir_seen, 0);
    chk("cb_next", exec_active, 1);
    $display("test flow done");
  endtask : t_flow

  // Table read and write in all four pointer modes
  task automatic t_table();
    for (int i = 0; i < 8; i++) begin
      step({12'h000, 1'b1, i[2], i[1:0]}, 1'b0);
      chk("tbl_rd", tbl_read, !i[2]);
      chk("tbl_wr", tbl_write, i[2]);
      chk("tbl_pre", tbl_pre_inc, i[1:0] == 2'h3);
      chk("tbl_post", tbl_post_step, i[1] ^ i[0]);
      chk("tbl_down", tbl_step_down, i[1:0] == 2'h2);
    end
    $display("test table done");
  endtask : t_table

  // Skips over single and double words, taken and not taken
  task automatic t_skip();
    step(16'h5c10, 1'b0);
    chk("skip_flag", ins_skip, 1);
    step(16'h0455, 1'b1);
    chk("skip_sup", exec_active, 0);
    step(16'h0455, 1'b0);
    chk("skip_after", exec_active, 1);
    step(16'h8110, 1'b0);
    step(16'h0466, 1'b0);
    chk("noskip", exec_active, 1);
    chk("noskip_f", file_addr, 8'h66);
    step(16'h5c10, 1'b0);
    step(16'hef12, 1'b1);
    chk("sk2_w1", exec_active, 0);
    step(16'hf345, 1'b0);
    chk("sk2_w2", exec_active, 0);
    step(16'h0477, 1'b0);
    chk("sk2_next", exec_active, 1);
    chk("sk2_f", file_addr, 8'h77);
    $display("test skip done");
  endtask : t_skip

  // Extended operations enabled and disabled
  task automatic t_ext();
    ext_set_enable = 1'b1;
    for (int op = 0; op < 8; op++) begin
      step({4'hb, op[2:0], 1'b0, 8'h11}, 1'b0);
      chk("ext_v", ext_valid, 1);
      chk("ext_op", ext_op, op);
      chk("ext_nop", ins_nop, 0);
    end
    ext_set_enable = 1'b0;
    step(16'hb211, 1'b0);
    chk("ext_off_v", ext_valid, 0);
    chk("ext_off_nop", ins_nop, 1);
    $display("test extended done");
  endtask : t_ext

  // Counts and verdict
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    @(negedge mclk);
    t_reset();
    t_byte();
    t_bit();
    t_lit();
    t_flow();
    t_table();
    t_skip();
    t_ext();
    close_out();
  end
endmodule : mcu_instruction_format_timing_tb
`default_nettype wire
